// ### rcsr_div.sv
// Divider chain with one-second, pre-update and periodic tap events
`timescale 1ns/1ps
`default_nettype none
module rcsr_div #(
   parameter int unsigned STAGES = rcsr_pkg::DIV_STAGES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   rcsr_time_if.div t
);
   typedef struct packed {
      logic [STAGES-1:0] cnt;
      logic pre;
      logic sec;
      logic per;
   } rcsr_div_state_type;
   localparam logic [14:0] PRE_AT = rcsr_pkg::SEC_LAST - 15'(rcsr_pkg::UIP_LEAD_TICKS);
   rcsr_div_state_type q, d;
   logic [4:0] tap;
   logic [STAGES-1:0] mask;

   always_comb begin
      // Codes 1 and 2 reuse the slow taps of codes 8 and 9
      tap = (t.rate >= rcsr_pkg::RATE_FAST_FIRST) ? 5'(t.rate) - rcsr_pkg::TAP_FAST_BASE :
            5'(t.rate) + rcsr_pkg::TAP_SLOW_BASE;
      mask = (STAGES'(1) << (tap + 5'h01)) - STAGES'(1);
      d = q;
      d.pre = 1'b0;
      d.sec = 1'b0;
      d.per = 1'b0;
      if (!t.run) begin
         // Held at half count so the first second lands 0.5 s after release
         d.cnt = rcsr_pkg::HALF_PRELOAD[STAGES-1:0];
      end else if (t.osc_tick) begin
         d.cnt = q.cnt + STAGES'(1);
         d.sec = (q.cnt[14:0] == rcsr_pkg::SEC_LAST);
         d.pre = (q.cnt[14:0] == PRE_AT);
         d.per = (t.rate != rcsr_pkg::RATE_OFF) && ((q.cnt & mask) == mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign t.pre_evt = q.pre;
   assign t.sec_evt = q.sec;
   assign t.per_evt = q.per;
endmodule
`default_nettype wire

// ### rcsr_pkg.sv
// Shared constants for the clock control and status register block
package rcsr_pkg;
   localparam int unsigned DIV_STAGES = 22;
   localparam int unsigned OSC_NS = 30517;
   localparam int unsigned UIP_LEAD_NS = 244000;
   localparam int unsigned UIP_LEAD_TICKS = (UIP_LEAD_NS + OSC_NS - 1) / OSC_NS;
   localparam int unsigned UPD_CYCLE_NS = 1948000;
   localparam int unsigned UPD_TICKS = (UPD_CYCLE_NS + OSC_NS - 1) / OSC_NS;
   localparam logic [21:0] HALF_PRELOAD = 22'h004000;
   localparam logic [14:0] SEC_LAST = 15'h7fff;
   localparam logic [2:0] DIV_RST_CODE = 3'b001;
   localparam logic [1:0] DIV_RST_TOP = 2'b11;
   localparam logic [3:0] RATE_OFF = 4'h0;
   localparam logic [3:0] RATE_FAST_FIRST = 4'h3;
   localparam logic [4:0] TAP_FAST_BASE = 5'h02;
   localparam logic [4:0] TAP_SLOW_BASE = 5'h05;
   localparam logic [7:0] IDX_SEC = 8'h00;
   localparam logic [7:0] IDX_SEC_ALM = 8'h01;
   localparam logic [7:0] IDX_MIN = 8'h02;
   localparam logic [7:0] IDX_MIN_ALM = 8'h03;
   localparam logic [7:0] IDX_HOUR = 8'h04;
   localparam logic [7:0] IDX_HOUR_ALM = 8'h05;
   localparam logic [7:0] IDX_DAY = 8'h07;
   localparam logic [7:0] IDX_DIV_RATE = 8'h0a;
   localparam logic [7:0] IDX_IRQ_FMT = 8'h0b;
   localparam logic [7:0] IDX_FLAGS = 8'h0c;
   localparam logic [7:0] IDX_VALID_DAY = 8'h0d;
   localparam logic [7:0] IDX_CENTURY = 8'h32;
   localparam logic [1:0] ALM_DONT_CARE = 2'b11;
   localparam logic [7:0] CENT_BCD_MAX = 8'h39;
   localparam logic [7:0] CENT_BIN_MAX = 8'h3f;
   localparam int unsigned IDX_LSB = 2;
endpackage

// ### rcsr_regs.sv
// Clock control/status registers, flags, CMOS bytes and APB slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Divider select codes run, reset or test; 001 and 11x hold, all others run, no test mode
// - First update half second after reset release
// - Divider and rate bits survive main reset
// - Rate picks one of 13 taps, 0 off
// - Period follows rate code table
// - Periodic flag sets regardless of enable
// - Periodic enable gates request, main reset clears
// - Freeze bit aborts and blocks updates
// - Alarm flag on time match, don't-care codes
// - Update enable cleared by reset, freeze rise
// - Daylight bit and reserved bit read zero
// - Binary format bit host-only, survives reset
// - Hour format bit host-only, survives reset
// - Request flag is any flag-enable pair
// - Flag read clears flags; main reset too
// - Update-end flag set after each update
// - Low four flag bits read zero
// - Valid bit cleared on power loss, read sets if power good
// - Day alarm byte, bit 6 zero, gated read
// - Century byte increments on year wrap
// - General-purpose bytes always accessible; writes are ignored while main reset is high
// - Updates only when unfrozen and dividing
// - Pending bit leads update, held till end
module rcsr_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_tick,
   input wire logic main_power_on_reset,
   input wire logic power_good,
   input wire logic both_power_lost,
   input wire logic year_wrap,
   output logic irq_out_n,
   output logic update_tick
);
   typedef struct packed {
      logic [255:0][7:0] ram;
      logic [2:0] divider_select;
      logic [3:0] rate_select;
      logic freeze;
      logic periodic_irq_enable;
      logic alarm_irq_enable;
      logic update_end_irq_enable;
      logic binary_format;
      logic hour_24;
      logic periodic_flag;
      logic alarm_flag;
      logic update_end_flag;
      logic valid_ram_time;
      logic [5:0] day_alarm;
      logic [7:0] rdata;
      logic [7:0] acc_idx;
      logic pready;
      logic pslverr;
      logic irq_n;
      logic upd_tick;
   } rcsr_state_type;

   rcsr_state_type q, d;
   rcsr_time_if tif ();

   assign tif.osc_tick = osc_tick;
   assign tif.rate = q.rate_select;
   assign tif.freeze = q.freeze;
   // Codes 001 and 11x hold the chain; all others let it count
   assign tif.run = !((q.divider_select == rcsr_pkg::DIV_RST_CODE) ||
                      (q.divider_select[2:1] == rcsr_pkg::DIV_RST_TOP));

   rcsr_div #(
      .STAGES(rcsr_pkg::DIV_STAGES)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .t(tif.div)
   );

   rcsr_upd u_upd (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .t(tif.seq)
   );

   function automatic logic alm_hit(input logic [7:0] tm, input logic [7:0] al);
      return (al[7:6] == rcsr_pkg::ALM_DONT_CARE) || (al == tm);
   endfunction

   function automatic logic [7:0] cent_inc(input logic [7:0] v, input logic bin);
      logic [7:0] r;
      r = v + 8'h01;
      if (bin) begin
         if (v >= rcsr_pkg::CENT_BIN_MAX) begin
            r = 8'h00;
         end
      end else if (v >= rcsr_pkg::CENT_BCD_MAX) begin
         r = 8'h00;
      end else if (v[3:0] == 4'h9) begin
         r = {v[7:4] + 4'h1, 4'h0};
      end
      return r;
   endfunction

   function automatic logic irq_pairs(input rcsr_state_type s);
      return (s.periodic_flag && s.periodic_irq_enable) ||
             (s.alarm_flag && s.alarm_irq_enable) ||
             (s.update_end_flag && s.update_end_irq_enable);
   endfunction

   function automatic logic [7:0] rd_byte(input rcsr_state_type s, input logic [7:0] idx,
                                          input logic pend);
      logic [7:0] r;
      r = s.ram[idx];
      case (idx)
         rcsr_pkg::IDX_DIV_RATE: begin
            r = {pend, s.divider_select, s.rate_select};
         end
         rcsr_pkg::IDX_IRQ_FMT: begin
            r = {s.freeze, s.periodic_irq_enable, s.alarm_irq_enable,
                 s.update_end_irq_enable, 1'b0, s.binary_format, s.hour_24, 1'b0};
         end
         rcsr_pkg::IDX_FLAGS: begin
            r = {irq_pairs(s), s.periodic_flag, s.alarm_flag, s.update_end_flag,
                 4'h0};
         end
         rcsr_pkg::IDX_VALID_DAY: begin
            r = {s.valid_ram_time, 1'b0,
                 s.alarm_irq_enable ? s.day_alarm : 6'h00};
         end
         default: begin
            r = s.ram[idx];
         end
      endcase
      return r;
   endfunction

   logic [7:0] idx;
   logic bad_addr;
   logic day_ok;
   logic [3:0] clr_mask;

   always_comb begin
      idx = paddr[rcsr_pkg::IDX_LSB +: 8];
      bad_addr = |paddr[11:10];
      clr_mask = 4'h0;
      day_ok = (q.day_alarm == 6'h00) ||
               (q.day_alarm[5:4] == rcsr_pkg::ALM_DONT_CARE) ||
               (q.day_alarm == q.ram[rcsr_pkg::IDX_DAY][5:0]);
      d = q;
      d.upd_tick = tif.done;

      // Counting engine reports a year wrap; a same-cycle host write wins below
      if (year_wrap) begin
         d.ram[rcsr_pkg::IDX_CENTURY] =
            cent_inc(q.ram[rcsr_pkg::IDX_CENTURY], q.binary_format);
      end

      // Setup phase: sample read data a cycle early so prdata is a flop
      if (psel && !penable) begin
         d.pready = 1'b1;
         d.pslverr = bad_addr;
         d.acc_idx = idx;
         d.rdata = bad_addr ? 8'h00 : rd_byte(q, idx, tif.pending);
      end else if (psel && penable && q.pready) begin
         d.pready = 1'b0;
         d.pslverr = 1'b0;
         // Host lockout while main power is coming up
         if (!q.pslverr && !main_power_on_reset) begin
            if (pwrite) begin
               case (q.acc_idx)
                  rcsr_pkg::IDX_DIV_RATE: begin
                     d.divider_select = pwdata[6:4];
                     d.rate_select = pwdata[3:0];
                  end
                  rcsr_pkg::IDX_IRQ_FMT: begin
                     d.freeze = pwdata[7];
                     d.periodic_irq_enable = pwdata[6];
                     d.alarm_irq_enable = pwdata[5];
                     d.update_end_irq_enable = pwdata[4];
                     d.binary_format = pwdata[2];
                     d.hour_24 = pwdata[1];
                     if (pwdata[7] && !q.freeze) begin
                        d.update_end_irq_enable = 1'b0;
                     end
                  end
                  rcsr_pkg::IDX_FLAGS: begin
                     // Flag register takes no writes
                     d.acc_idx = q.acc_idx;
                  end
                  rcsr_pkg::IDX_VALID_DAY: begin
                     d.day_alarm = pwdata[5:0];
                  end
                  default: begin
                     d.ram[q.acc_idx] = pwdata[7:0];
                  end
               endcase
            end else begin
               if (q.acc_idx == rcsr_pkg::IDX_FLAGS) begin
                  // Only bits seen by the reader are erased
                  clr_mask = q.rdata[7:4];
               end
               if (q.acc_idx == rcsr_pkg::IDX_VALID_DAY && power_good) begin
                  d.valid_ram_time = 1'b1;
               end
            end
         end
      end

      if (clr_mask[2]) begin
         d.periodic_flag = 1'b0;
      end
      if (clr_mask[1]) begin
         d.alarm_flag = 1'b0;
      end
      if (clr_mask[0]) begin
         d.update_end_flag = 1'b0;
      end

      // Sets after clears: an event in the clearing cycle survives
      if (tif.per_evt) begin
         d.periodic_flag = 1'b1;
      end
      if (tif.done) begin
         d.update_end_flag = 1'b1;
         if (alm_hit(q.ram[rcsr_pkg::IDX_SEC], q.ram[rcsr_pkg::IDX_SEC_ALM]) &&
             alm_hit(q.ram[rcsr_pkg::IDX_MIN], q.ram[rcsr_pkg::IDX_MIN_ALM]) &&
             alm_hit(q.ram[rcsr_pkg::IDX_HOUR], q.ram[rcsr_pkg::IDX_HOUR_ALM]) &&
             day_ok) begin
            d.alarm_flag = 1'b1;
         end
      end

      if (both_power_lost) begin
         d.valid_ram_time = 1'b0;
      end

      // Main reset spares divider, rate, freeze and format bits
      if (main_power_on_reset) begin
         d.periodic_irq_enable = 1'b0;
         d.alarm_irq_enable = 1'b0;
         d.update_end_irq_enable = 1'b0;
         d.periodic_flag = 1'b0;
         d.alarm_flag = 1'b0;
         d.update_end_flag = 1'b0;
      end

      d.irq_n = !irq_pairs(d);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.irq_n <= 1'b1;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign prdata = {24'h000000, q.rdata};
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign irq_out_n = q.irq_n;
   assign update_tick = q.upd_tick;
endmodule
`default_nettype wire

// ### rcsr_regs_asserts.sv
// Port-level checker for the clock control register block
`timescale 1ns/1ps
`default_nettype none
module rcsr_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic osc_tick,
   input wire logic main_power_on_reset,
   input wire logic power_good,
   input wire logic both_power_lost,
   input wire logic year_wrap,
   input wire logic irq_out_n,
   input wire logic update_tick
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable && clk_en;
   endsequence
   sequence s_flag_rd;
      pready && psel && !pwrite && paddr == 12'h030;
   endsequence
   sequence s_por2;
      (main_power_on_reset && clk_en) [*2];
   endsequence
   chk_ready_rise: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready && clk_en |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_unmapped: assert property (pready |-> pslverr == (paddr[11:10] != 2'b00))
      else $error("error response wrong");
   chk_flags_low: assert property (s_flag_rd |-> prdata[3:0] == 4'h0)
      else $error("low flag bits not zero");
   // Read data is latched at setup, so compare with the pin of that cycle
   chk_irq_request_flag_pin: assert property (s_flag_rd |-> $past(irq_out_n) == !prdata[7])
      else $error("request flag and pin disagree");
   chk_por_release: assert property (s_por2 |=> irq_out_n)
      else $error("pin low after main reset");
   chk_tick_single: assert property (update_tick && clk_en |=> !update_tick)
      else $error("update tick too long");
   chk_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
endmodule
bind rcsr_regs rcsr_chk u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .osc_tick, .main_power_on_reset, .power_good,
   .both_power_lost, .year_wrap, .irq_out_n, .update_tick);
`default_nettype wire

// ### rcsr_time_if.sv
// Link between register core, divider chain and update sequencer
`timescale 1ns/1ps
`default_nettype none
interface rcsr_time_if;
   logic osc_tick;
   logic run;
   logic freeze;
   logic [3:0] rate;
   logic pre_evt;
   logic sec_evt;
   logic per_evt;
   logic pending;
   logic done;
   modport div (input osc_tick, run, rate, output pre_evt, sec_evt, per_evt);
   modport seq (input osc_tick, run, freeze, pre_evt, sec_evt, output pending, done);
   modport core (output osc_tick, run, freeze, rate, input per_evt, pending, done);
endinterface
`default_nettype wire

// ### rcsr_upd.sv
// Update cycle sequencer: pending window, busy interval, end pulse
`timescale 1ns/1ps
`default_nettype none
module rcsr_upd (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   rcsr_time_if.seq t
);
   typedef enum logic [1:0] {UPD_IDLE, UPD_PEND, UPD_BUSY} rcsr_upd_st_type;
   typedef struct packed {
      rcsr_upd_st_type st;
      logic [6:0] cnt;
      logic pend;
      logic done;
   } rcsr_upd_state_type;
   rcsr_upd_state_type q, d;

   always_comb begin
      d = q;
      d.done = 1'b0;
      if (t.freeze || !t.run) begin
         // Freeze aborts a cycle already under way
         d.st = UPD_IDLE;
         d.pend = 1'b0;
      end else begin
         case (q.st)
            UPD_IDLE: begin
               if (t.pre_evt) begin
                  d.st = UPD_PEND;
                  d.pend = 1'b1;
               end else if (t.sec_evt) begin
                  d.st = UPD_BUSY;
                  d.cnt = 7'h00;
                  d.pend = 1'b1;
               end
            end
            UPD_PEND: begin
               if (t.sec_evt) begin
                  d.st = UPD_BUSY;
                  d.cnt = 7'h00;
               end
            end
            UPD_BUSY: begin
               if (t.osc_tick) begin
                  d.cnt = q.cnt + 7'h01;
                  if (q.cnt == 7'(rcsr_pkg::UPD_TICKS - 1)) begin
                     d.st = UPD_IDLE;
                     d.pend = 1'b0;
                     d.done = 1'b1;
                  end
               end
            end
            default: begin
               d.st = UPD_IDLE;
               d.pend = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign t.pending = q.pend;
   assign t.done = q.done;
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the clock control register block
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [11:0] RA = 12'h028;
   localparam logic [11:0] RB = 12'h02c;
   localparam logic [11:0] RC = 12'h030;
   localparam logic [11:0] RD = 12'h034;
   localparam logic [11:0] CEN = 12'h0c8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic main_power_on_reset = 1'b0;
   logic power_good = 1'b0;
   logic both_power_lost = 1'b0;
   logic year_wrap = 1'b0;
   logic clk_en = 1'b1;
   logic [31:0] prdata;
   logic pready, pslverr, irq_out_n, update_tick;
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   int ticks = 0;
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (update_tick === 1'b1) ticks <= ticks + 1;
   end
   // Time base ticks every cycle so one second is 32768 cycles
   rcsr_regs u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .osc_tick(1'b1), .main_power_on_reset, .power_good,
      .both_power_lost, .year_wrap, .irq_out_n, .update_tick);
   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
         output logic [7:0] r, output logic er);
      int i;
      logic rdy;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      rdy = 1'b0;
      while (!rdy && i < 20) begin
         @(posedge pclk);
         rdy = (pready === 1'b1);
         i++;
      end
      r = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!rdy) begin
         fails++;
         end_of_test();
      end
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rc(input logic [11:0] a, input logic [7:0] x);
      logic [7:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk({24'h000000, r}, {24'h000000, x});
   endtask
   task automatic wrap_year;
      year_wrap <= 1'b1;
      @(posedge pclk);
      year_wrap <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wirq(input int lim, input bit must, output int n);
      n = 0;
      while (irq_out_n !== 1'b0 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (must && n >= lim) begin
         fails++;
         end_of_test();
      end
   endtask
   task automatic t_regs;
      logic [7:0] r;
      logic e;
      rc(RA, 8'h00);
      wr(RA, 8'hff);
      rc(RA, 8'h7f);
      wr(RB, 8'hff);
      rc(RB, 8'he6);
      main_power_on_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      main_power_on_reset <= 1'b0;
      @(posedge pclk);
      rc(RA, 8'h7f);
      rc(RB, 8'h86);
      wr(RC, 8'hff);
      rc(RC, 8'h00);
      apb(1'b0, 12'hc28, 8'h00, r, e);
      chk({31'h0, e}, 32'h1);
      chk({24'h0, r}, 32'h0);
   endtask
   task automatic t_day;
      rc(RD, 8'h00);
      wr(RD, 8'h7f);
      rc(RD, 8'h00);
      power_good <= 1'b1;
      @(posedge pclk);
      rc(RD, 8'h00);
      rc(RD, 8'h80);
      wr(RB, 8'ha6);
      rc(RD, 8'hbf);
      both_power_lost <= 1'b1;
      @(posedge pclk);
      both_power_lost <= 1'b0;
      @(posedge pclk);
      rc(RD, 8'h3f);
   endtask
   task automatic t_cent;
      wr(CEN, 8'h09);
      wrap_year();
      rc(CEN, 8'h0a);
      wr(RB, 8'ha2);
      wr(CEN, 8'h19);
      wrap_year();
      rc(CEN, 8'h20);
      wr(12'h200, 8'h5a);
      wr(12'h3fc, 8'ha5);
      rc(12'h200, 8'h5a);
      rc(12'h3fc, 8'ha5);
   endtask
   task automatic t_upd;
      int n, t0, tp;
      logic [7:0] r;
      logic e;
      wr(RA, 8'h70);
      wr(RB, 8'h10);
      rc(RC, 8'h00);
      wr(RA, 8'h20);
      t0 = cyc;
      n = 0;
      r = 8'h00;
      while (r[7] !== 1'b1 && n < 9000) begin
         apb(1'b0, RA, 8'h00, r, e);
         n++;
      end
      if (n >= 9000) begin
         fails++;
         end_of_test();
      end
      tp = cyc - t0;
      chk({31'h0, tp inside {[16360:16390]}}, 32'h1);
      wirq(300, 1'b1, n);
      tp = cyc - t0;
      chk({31'h0, tp inside {[16440:16470]}}, 32'h1);
      rc(RC, 8'hb0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq_out_n}, 32'h1);
      chk(ticks, 1);
      wr(RB, 8'h90);
      rc(RB, 8'h80);
      rc(RA, 8'h20);
      repeat (34000) @(posedge pclk);
      chk(ticks, 1);
   endtask
   task automatic t_per;
      int n, t1, k;
      logic v;
      logic [7:0] r;
      logic e;
      logic [3:0] cs [4] = '{4'h1, 4'h2, 4'h5, 4'h8};
      int pe [4] = '{128, 256, 16, 128};
      wr(RB, 8'hc0);
      for (k = 0; k < 4; k++) begin
         wr(RA, {4'h2, cs[k]});
         apb(1'b0, RC, 8'h00, r, e);
         wirq(600, 1'b1, n);
         t1 = cyc;
         rc(RC, 8'hc0);
         wirq(600, 1'b1, n);
         chk(cyc - t1, pe[k]);
      end
      wr(RB, 8'h80);
      apb(1'b0, RC, 8'h00, r, e);
      repeat (300) @(posedge pclk);
      chk({31'h0, irq_out_n}, 32'h1);
      rc(RC, 8'h40);
      // Clock enable low must freeze the chain and the pin
      wr(RB, 8'hc0);
      apb(1'b0, RC, 8'h00, r, e);
      clk_en <= 1'b0;
      @(posedge pclk);
      v = irq_out_n;
      repeat (300) @(posedge pclk);
      chk({31'h0, irq_out_n}, {31'h0, v});
      clk_en <= 1'b1;
      @(posedge pclk);
      apb(1'b0, RC, 8'h00, r, e);
      wirq(600, 1'b1, n);
      chk({31'h0, irq_out_n}, 32'h0);
      wr(RA, 8'h20);
      apb(1'b0, RC, 8'h00, r, e);
      wr(RB, 8'hc0);
      wirq(600, 1'b0, n);
      chk(n, 600);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_day();
      t_cent();
      t_upd();
      t_per();
      end_of_test();
   end
endmodule
`default_nettype wire
